// [pkg/actuation_map.vh]
// Register map, field layout and reset values of the actuation voting latch.
// Included by the top design file and the bench; holds definitions only.
`ifndef ACTUATION_MAP_VH
`define ACTUATION_MAP_VH

// ----------------------------------------------------------------
// Sizes
// ----------------------------------------------------------------
`define NFN 10
`define NOUT 14
`define NSYNC 75

// ----------------------------------------------------------------
// Safety function indices
// ----------------------------------------------------------------
`define FN_AREA 0
`define FN_BED1 1
`define FN_BED2 2
`define FN_BED3 3
`define FN_VAC 4
`define FN_TRN_A 5
`define FN_TRN_B 6
`define FN_TRN_C 7
`define FN_COL_A 8
`define FN_COL_B 9

// ----------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------
`define OFS_LATCH 8'h00
`define OFS_VOTE 8'h04
`define OFS_OUT 8'h08
`define OFS_CHAN 8'h0C
`define OFS_CELL 8'h10
`define OFS_MAN 8'h14
`define OFS_IND_SEL 8'h18

// ----------------------------------------------------------------
// Indication selector codes and reset values
// ----------------------------------------------------------------
`define IND_CHAN 2'h0
`define IND_CELL 2'h1
`define IND_LOGIC 2'h2
`define IND_EQUIP 2'h3
`define IND_SEL_RST 2'h0
`define OUT_RST 14'h3FFF

`endif

// [hw/in_sync.v]
// Two-stage synchroniser for the discrete trip, position and operator inputs.
// Assumes the inputs may change at any time relative to pclk.
`timescale 1ns/1ps
`default_nettype none

module in_sync #(
	parameter W = 8
)(
	input wire pclk,
	input wire presetn,
	input wire [W-1:0] raw,
	output wire [W-1:0] sync
);

	reg [W-1:0] meta_q;
	reg [W-1:0] sync_q;

	// ----------------------------------------------------------------
	// Two flops; first stage feeds only the second
	// ----------------------------------------------------------------
	always @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			meta_q <= {W{1'b0}};
			sync_q <= {W{1'b0}};
		end
		else
		begin
			meta_q <= raw;
			sync_q <= meta_q;
		end
	end

	assign sync = sync_q;

endmodule // in_sync

`default_nettype wire

// [hw/act_latch.v]
// Seal-in latch for one protective action.
// Assumes trip and manual request are already synchronised to pclk.
`timescale 1ns/1ps
`default_nettype none

module act_latch (
	input wire pclk,
	input wire presetn,
	input wire trip,
	input wire man,
	input wire op_reset,
	output wire act,
	output wire released
);

	reg act_q;
	reg rel_q;
	wire act_d;

	// ----------------------------------------------------------------
	// Latch: set by trip or manual, cleared only by operator
	// ----------------------------------------------------------------
	// No bypass term: manual always sets
	assign act_d = trip | man | (act_q & ~op_reset);

	always @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			act_q <= 1'b0;
			rel_q <= 1'b0;
		end
		else
		begin
			act_q <= act_d;
			rel_q <= act_q & ~act_d;
		end
	end

	assign act = act_q;
	assign released = rel_q;

endmodule // act_latch

`default_nettype wire

// [hw/safety_actuation_voting_latch.v]
// Actuation logic for one division: votes trips, latches protective actions,
// arbitrates output_interface_module outputs and drives indication.
// Assumes an APB master on pclk and discrete inputs of any timing.
`timescale 1ns/1ps
`default_nettype none
`include "actuation_map.vh"

module safety_actuation_voting_latch (
	input wire pclk,
	input wire presetn,
	input wire psel,
	input wire penable,
	input wire pwrite,
	input wire [7:0] paddr,
	input wire [31:0] pwdata,
	output wire [31:0] prdata,
	output wire pready,
	output wire pslverr,
	input wire [2:0] rad_hi,
	input wire [5:0] co_hi,
	input wire [1:0] lift_liq,
	input wire [1:0] drain_liq,
	input wire [15:0] cell_exh_hi,
	input wire [15:0] cell_sup_hi,
	input wire col_a_up,
	input wire col_a_lo,
	input wire col_b_up,
	input wire col_b_lo,
	input wire [9:0] man_req,
	input wire op_reset,
	input wire ns_enable,
	input wire [13:0] ns_cmd,
	output wire [13:0] out_energize,
	output wire [9:0] act_status,
	output wire [31:0] ind_data
);

	// ----------------------------------------------------------------
	// Voting functions
	// ----------------------------------------------------------------
	function vote2of3;
		input [2:0] v;
		begin
			vote2of3 = (v[0] & v[1]) | (v[0] & v[2]) | (v[1] & v[2]);
		end
	endfunction

	function vote1of2;
		input [1:0] v;
		begin
			vote1of2 = v[0] | v[1];
		end
	endfunction

	// ----------------------------------------------------------------
	// Input synchronisation
	// ----------------------------------------------------------------
	wire [`NSYNC-1:0] raw_all;
	wire [`NSYNC-1:0] syn_all;
	wire [2:0] s_rad;
	wire [5:0] s_co;
	wire [1:0] s_lift;
	wire [1:0] s_drain;
	wire [15:0] s_exh;
	wire [15:0] s_sup;
	wire [3:0] s_valve;
	wire [9:0] s_man;
	wire s_rst;
	wire s_ns_en;
	wire [13:0] s_ns_cmd;

	assign raw_all = {ns_cmd, ns_enable, op_reset, man_req,
		col_b_lo, col_b_up, col_a_lo, col_a_up,
		cell_sup_hi, cell_exh_hi, drain_liq, lift_liq, co_hi, rad_hi};

	in_sync #(
		.W(`NSYNC)
	) u_sync (
		.pclk(pclk),
		.presetn(presetn),
		.raw(raw_all),
		.sync(syn_all)
	);

	assign s_rad = syn_all[2:0];
	assign s_co = syn_all[8:3];
	assign s_lift = syn_all[10:9];
	assign s_drain = syn_all[12:11];
	assign s_exh = syn_all[28:13];
	assign s_sup = syn_all[44:29];
	assign s_valve = syn_all[48:45];
	assign s_man = syn_all[58:49];
	assign s_rst = syn_all[59];
	assign s_ns_en = syn_all[60];
	assign s_ns_cmd = syn_all[74:61];

	// ----------------------------------------------------------------
	// Automatic trip votes
	// ----------------------------------------------------------------
	wire [7:0] cell_trip;
	wire [9:0] trip;

	genvar c;
	generate
		for (c = 0; c < 8; c = c + 1)
		begin : g_cell
			// Either division, either pressure
			assign cell_trip[c] = vote1of2(s_exh[2*c+1:2*c]) |
				vote1of2(s_sup[2*c+1:2*c]);
		end
	endgenerate

	assign trip[`FN_AREA] = vote2of3(s_rad);
	assign trip[`FN_BED1] = vote1of2(s_co[1:0]);
	assign trip[`FN_BED2] = vote1of2(s_co[3:2]);
	assign trip[`FN_BED3] = vote1of2(s_co[5:4]);
	assign trip[`FN_VAC] = vote1of2(s_lift) | vote1of2(s_drain);
	assign trip[`FN_TRN_A] = |cell_trip[1:0];
	assign trip[`FN_TRN_B] = |cell_trip[4:2];
	assign trip[`FN_TRN_C] = |cell_trip[7:5];
	assign trip[`FN_COL_A] = s_valve[0] & s_valve[1];
	assign trip[`FN_COL_B] = s_valve[2] & s_valve[3];

	// ----------------------------------------------------------------
	// Protective action latches
	// ----------------------------------------------------------------
	wire [9:0] act;
	wire [9:0] rel;
	wire [9:0] req;

	genvar f;
	generate
		for (f = 0; f < `NFN; f = f + 1)
		begin : g_latch
			act_latch u_latch (
				.pclk(pclk),
				.presetn(presetn),
				.trip(trip[f]),
				.man(s_man[f]),
				.op_reset(s_rst),
				.act(act[f]),
				.released(rel[f])
			);
		end
	endgenerate

	// Live or latched request; manual ranks with automatic
	assign req = act | trip | s_man;

	// ----------------------------------------------------------------
	// Output interface module arbitration
	// ----------------------------------------------------------------
	// Bit order: col A x3, col B x3, area, beds x3, vac, trains x3
	wire [13:0] req_o;
	wire [13:0] rel_o;
	reg [13:0] out_q;
	reg [13:0] out_d;

	assign req_o = {req[7:5], req[4], req[3:1], req[0],
		{3{req[9]}}, {3{req[8]}}};
	assign rel_o = {rel[7:5], rel[4], rel[3:1], rel[0],
		{3{rel[9]}}, {3{rel[8]}}};

	integer i;
	always @*
	begin
		out_d = out_q;
		for (i = 0; i < `NOUT; i = i + 1)
		begin
			if (req_o[i])
				out_d[i] = 1'b0;
			else if (rel_o[i])
				out_d[i] = 1'b1;
			else if (s_ns_en)
				out_d[i] = s_ns_cmd[i];
			else
				out_d[i] = out_q[i];
		end
	end

	always @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			out_q <= `OUT_RST;
		else
			out_q <= out_d;
	end

	// ----------------------------------------------------------------
	// Status words
	// ----------------------------------------------------------------
	wire [31:0] w_latch;
	wire [31:0] w_vote;
	wire [31:0] w_out;
	wire [31:0] w_chan;
	wire [31:0] w_cell;
	wire [31:0] w_man;

	assign w_latch = {22'h000000, act};
	assign w_vote = {22'h000000, trip};
	assign w_out = {18'h00000, out_q};
	assign w_chan = {13'h0000, s_ns_en, s_rst, s_valve, s_drain, s_lift,
		s_co, s_rad};
	assign w_cell = {s_sup, s_exh};
	assign w_man = {8'h00, s_ns_cmd, s_man};

	// ----------------------------------------------------------------
	// APB slave, no wait state: answer registered in setup cycle
	// ----------------------------------------------------------------
	reg [1:0] ind_sel_q;
	reg pready_q;
	reg pslverr_q;
	reg [31:0] prdata_q;
	reg [31:0] rd_val;
	reg hit;
	wire setup;
	wire wr_go;

	assign setup = psel & ~penable;
	assign wr_go = psel & penable & pready_q & pwrite;

	always @*
	begin
		hit = 1'b1;
		rd_val = 32'h00000000;
		case (paddr)
			`OFS_LATCH: rd_val = w_latch;
			`OFS_VOTE: rd_val = w_vote;
			`OFS_OUT: rd_val = w_out;
			`OFS_CHAN: rd_val = w_chan;
			`OFS_CELL: rd_val = w_cell;
			`OFS_MAN: rd_val = w_man;
			`OFS_IND_SEL: rd_val = {30'h00000000, ind_sel_q};
			default: hit = 1'b0;
		endcase
	end

	always @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			pready_q <= 1'b0;
			pslverr_q <= 1'b0;
			prdata_q <= 32'h00000000;
			ind_sel_q <= `IND_SEL_RST;
		end
		else
		begin
			pready_q <= setup;
			if (setup)
			begin
				pslverr_q <= ~hit;
				prdata_q <= pwrite ? 32'h00000000 : rd_val;
			end
			else
			begin
				pslverr_q <= 1'b0;
				prdata_q <= 32'h00000000;
			end
			// Status registers are read-only; writes there are dropped
			if (wr_go && paddr == `OFS_IND_SEL)
				ind_sel_q <= pwdata[1:0];
		end
	end

	// ----------------------------------------------------------------
	// Indication outputs toward plant_control_system
	// ----------------------------------------------------------------
	reg [31:0] ind_q;
	reg [31:0] ind_d;

	always @*
	begin
		case (ind_sel_q)
			`IND_CHAN: ind_d = w_chan;
			`IND_CELL: ind_d = w_cell;
			`IND_LOGIC: ind_d = {12'h000, trip, act};
			`IND_EQUIP: ind_d = {8'h00, out_q, act};
			default: ind_d = 32'h00000000;
		endcase
	end

	always @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			ind_q <= 32'h00000000;
		else
			ind_q <= ind_d;
	end

	// ----------------------------------------------------------------
	// Outputs, all from flops
	// ----------------------------------------------------------------
	assign prdata = prdata_q;
	assign pready = pready_q;
	assign pslverr = pslverr_q;
	assign out_energize = out_q;
	assign act_status = act;
	assign ind_data = ind_q;

endmodule // safety_actuation_voting_latch

`default_nettype wire

// [sim/actuation_props.sv]
// Assertion checker for the actuation voting latch.
// Assumes binding onto the top module's ports.
`timescale 1ns/1ps
`default_nettype none
module actuation_props (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pready,
	input wire logic [2:0] rad_hi,
	input wire logic col_a_up,
	input wire logic col_a_lo,
	input wire logic [9:0] man_req,
	input wire logic op_reset,
	input wire logic ns_enable,
	input wire logic [13:0] ns_cmd,
	input wire logic [13:0] out_energize,
	input wire logic [9:0] act_status
);
// ----------------
// Properties
// ----------------
logic v2;
assign v2 = (rad_hi[0] & rad_hi[1]) | (rad_hi[2] & (rad_hi[0] | rad_hi[1]));
default clocking cb @(posedge pclk); endclocking
default disable iff (!presetn);
col_a_a: assert property ((col_a_up && col_a_lo)[*3] |-> ##[0:2]
	(act_status[8] && out_energize[2:0] == 3'h0)) else $error("column miss");
area_vote_a: assert property (v2[*3] |-> ##[0:2]
	(act_status[0] && !out_energize[6])) else $error("area vote miss");
man_wins_a: assert property (man_req[7][*3] |-> ##[0:2]
	(act_status[7] && !out_energize[13])) else $error("manual miss");
// Panel holds reset four cycles, so four samples is the longest overlap
reset_refused_a: assert property ((v2 && op_reset)[*4] |->
	act_status[0]) else $error("reset beat trip");
latch_hold_a: assert property ((!op_reset)[*3] |=>
	(act_status & $past(act_status)) == $past(act_status))
	else $error("latch lost");
// Margin of six covers the sync lag on enable and reset
no_rise_a: assert property ((!ns_enable && !op_reset)[*6] |=>
	(out_energize & ~$past(out_energize)) == 14'h0) else $error("output rose");
ns_follow_a: assert property ((ns_enable && !act_status[0]
	&& !man_req[0] && !v2 && $stable(ns_cmd[6]))[*8] |->
	out_energize[6] == ns_cmd[6]) else $error("nonsafety ignored");
apb_ready_a: assert property (psel && !penable |=> pready ##1 !pready)
	else $error("pready timing");
endmodule // actuation_props
bind safety_actuation_voting_latch actuation_props i_actuation_props (.pclk,
	.presetn, .psel, .penable, .pready, .rad_hi, .col_a_up, .col_a_lo,
	.man_req, .op_reset, .ns_enable, .ns_cmd, .out_energize, .act_status);
`default_nettype wire

// [sim/operator_panel.sv]
// Operator reset panel model: a press becomes a held reset level.
// Assumes the design clock and reset.
`timescale 1ns/1ps
`default_nettype none
module operator_panel #(
	parameter int HOLD = 4
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic press,
	output var logic op_reset
);
// ----------------
// Deliberate reset
// ----------------
logic [3:0] cnt_q;
always @(posedge pclk or negedge presetn)
begin
	if (!presetn)
		cnt_q <= 4'h0;
	else if (press)
		cnt_q <= HOLD[3:0];
	else if (cnt_q != 4'h0)
		cnt_q <= cnt_q - 4'h1;
end
// Only a press raises it, never the panel itself
assign op_reset = cnt_q != 4'h0;
endmodule // operator_panel
`default_nettype wire

// [sim/safety_actuation_voting_latch_bench.sv]
// Self-checking bench of the actuation voting latch.
// Assumes the design, its header, the panel model and the checker.
`timescale 1ns/1ps
`default_nettype none
`include "actuation_map.vh"
`define CHK(a, b) begin checked++; if ((a) !== (b)) begin n_errors++; \
	$display("ERROR %0t got %h want %h", $time, a, b); end end
module safety_actuation_voting_latch_bench;
// ----------------
// Signals
// ----------------
logic pclk = 1'h0, presetn = 1'h0, psel = 1'h0, penable = 1'h0;
logic pwrite = 1'h0, press = 1'h0, ns_enable = 1'h0;
logic col_a_up = 1'h0, col_a_lo = 1'h0, col_b_up = 1'h0, col_b_lo = 1'h0;
logic [7:0] paddr = 8'h00;
logic [31:0] pwdata = 32'h0;
logic [2:0] rad_hi = 3'h0;
logic [5:0] co_hi = 6'h00;
logic [1:0] lift_liq = 2'h0, drain_liq = 2'h0;
logic [15:0] cell_exh_hi = 16'h0000, cell_sup_hi = 16'h0000;
logic [9:0] man_req = 10'h000;
logic [13:0] ns_cmd = 14'h3FFF;
logic op_reset, pready, pslverr, er;
logic [31:0] prdata, ind_data, rd;
logic [13:0] out_energize;
logic [9:0] act_status;
int n_errors = 0, checked = 0, cyc = 0;
logic [9:0] act_tab [14];
logic [13:0] out_tab [14];
safety_actuation_voting_latch i_safety_actuation_voting_latch (.pclk,
	.presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
	.pslverr, .rad_hi, .co_hi, .lift_liq, .drain_liq, .cell_exh_hi,
	.cell_sup_hi, .col_a_up, .col_a_lo, .col_b_up, .col_b_lo, .man_req,
	.op_reset, .ns_enable, .ns_cmd, .out_energize, .act_status, .ind_data);
operator_panel i_operator_panel (.pclk, .presetn, .press, .op_reset);
always #12.5 pclk = ~pclk;
always @(posedge pclk)
begin
	cyc <= cyc + 1;
	if (cyc == 5000)
	begin
		n_errors++;
		final_report();
	end
end
// ----------------
// Tasks
// ----------------
task final_report;
	$display("errors %0d checks %0d", n_errors, checked);
	if (n_errors == 0 && checked > 0)
		$display("TB: PASS");
	else
		$display("TB: FAIL");
	$finish;
endtask
task wt(input int n);
	repeat (n) @(posedge pclk);
	@(negedge pclk);
endtask
task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
	int k;
	@(posedge pclk);
	psel <= 1'h1;
	penable <= 1'h0;
	pwrite <= w;
	paddr <= a;
	pwdata <= d;
	@(posedge pclk);
	penable <= 1'h1;
	k = 0;
	// Answer is taken at the rising edge that samples pready high
	do
	begin
		@(posedge pclk);
		k++;
	end
	while (pready !== 1'h1 && k < 20);
	if (pready !== 1'h1)
	begin
		n_errors++;
		$display("ERROR %0t no pready", $time);
	end
	rd = prdata;
	er = pslverr;
	psel <= 1'h0;
	penable <= 1'h0;
endtask
task push;
	@(posedge pclk);
	press <= 1'h1;
	@(posedge pclk);
	press <= 1'h0;
endtask
// Index 12 and 13 are one-sided votes that must not trip
task set_in(input int i);
	@(posedge pclk);
	case (i)
	0: rad_hi <= 3'h5;
	1: co_hi <= 6'h02;
	2: co_hi <= 6'h04;
	3: co_hi <= 6'h20;
	4: lift_liq <= 2'h2;
	5: drain_liq <= 2'h1;
	6: cell_exh_hi <= 16'h0004;
	7: cell_sup_hi <= 16'h0200;
	8: cell_exh_hi <= 16'h4000;
	9: {col_a_up, col_a_lo} <= 2'h3;
	10: {col_b_up, col_b_lo} <= 2'h3;
	11: {man_req, ns_enable, ns_cmd} <= {10'h080, 1'h1, 14'h3FFF};
	12: rad_hi <= 3'h4;
	13: col_a_up <= 1'h1;
	default:
	begin
		{rad_hi, co_hi, lift_liq, drain_liq} <= 13'h0000;
		{cell_exh_hi, cell_sup_hi} <= 32'h0;
		{col_a_up, col_a_lo, col_b_up, col_b_lo} <= 4'h0;
		{man_req, ns_enable} <= 11'h000;
	end
	endcase
endtask
task reg_cases;
	apb(1'h1, `OFS_IND_SEL, 32'h2);
	apb(1'h0, `OFS_IND_SEL, 32'h0);
	`CHK(rd, 32'h2)
	apb(1'h1, `OFS_OUT, 32'h0);
	apb(1'h0, `OFS_OUT, 32'h0);
	`CHK(rd, 32'h3FFF)
	apb(1'h0, 8'h40, 32'h0);
	`CHK({er, rd}, 33'h100000000)
endtask
task ns_cases;
	@(posedge pclk);
	ns_cmd <= 14'h0000;
	wt(8);
	`CHK(out_energize, `OUT_RST)
	@(posedge pclk);
	ns_enable <= 1'h1;
	wt(8);
	`CHK(out_energize, 14'h0000)
	@(posedge pclk);
	{ns_enable, ns_cmd} <= {1'h0, 14'h3FFF};
	wt(8);
	`CHK(out_energize, 14'h0000)
	@(posedge pclk);
	ns_enable <= 1'h1;
	wt(8);
	`CHK(out_energize, `OUT_RST)
endtask
task trip_cases;
	for (int i = 0; i < 14; i++)
	begin
		set_in(i);
		wt(6);
		`CHK(act_status, act_tab[i])
		`CHK(out_energize, out_tab[i])
		`CHK(ind_data[9:0], act_tab[i])
		push();
		wt(8);
		`CHK(act_status, act_tab[i])
		set_in(99);
		wt(6);
		`CHK(out_energize, out_tab[i])
		push();
		wt(8);
		`CHK({act_status, out_energize}, {10'h000, `OUT_RST})
	end
endtask
initial
begin
	act_tab = '{10'h001, 10'h002, 10'h004, 10'h008, 10'h010, 10'h010, 10'h020,
		10'h040, 10'h080, 10'h100, 10'h200, 10'h080, 10'h000, 10'h000};
	out_tab = '{14'h3FBF, 14'h3F7F, 14'h3EFF, 14'h3DFF, 14'h3BFF, 14'h3BFF,
		14'h37FF, 14'h2FFF, 14'h1FFF, 14'h3FF8, 14'h3FC7, 14'h1FFF,
		14'h3FFF, 14'h3FFF};
	repeat (3) @(posedge pclk);
	presetn <= 1'h1;
	reg_cases();
	ns_cases();
	set_in(99);
	trip_cases();
	final_report();
end
endmodule // safety_actuation_voting_latch_bench
`default_nettype wire
